/* File: verilog/flash_prot_pkg.sv */
// flash_prot_pkg: register map, field layout and codes of the flash
// configuration and protection register block.
// assumes a 32-bit avalon-mm bus with byte addresses, one word per register.
package flash_prot_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [9:0] IDX_TEST = 10'h102;
  localparam logic [9:0] IDX_CFG = 10'h103;
  localparam logic [9:0] IDX_PROT = 10'h104;
  localparam logic [9:0] IDX_EVT = 10'h110;
  localparam logic [9:0] IDX_MASK = 10'h111;
  localparam logic [9:0] IDX_FAULT = 10'h112;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;

  // ==========================================================
  // config register fields
  localparam int CFG_BUF_IE = 7;
  localparam int CFG_DONE_IE = 6;
  localparam int CFG_KEY_EN = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // ==========================================================
  // protection register fields and codes
  localparam int HI_MSB = 7;
  localparam int HI_LSB = 3;
  localparam int LO_MSB = 2;
  localparam logic [4:0] HI_NONE = 5'h1f;
  localparam logic [2:0] LO_NONE = 3'h7;
  localparam logic [5:0] KB_FULL = 6'h20;

  // backdoor enable field code meaning enabled
  localparam logic [1:0] BACKDOOR_ENABLE_FIELD_ON = 2'h2;

  // ==========================================================
  // event status bits (mask register has the same layout)
  localparam int EV_BUF = 0;
  localparam int EV_DONE = 1;
  localparam int EV_VIOL = 2;
  localparam int EV_MASS = 3;
  localparam int EV_N = 4;

  // fault register bits
  localparam int FLT_VIOL = 0;
  localparam int FLT_SPECIAL = 1;
  localparam int FLT_BACKDOOR_ENABLE_FIELD = 2;

  // command kinds from the command controller
  localparam logic [1:0] CMD_PROG = 2'h0;
  localparam logic [1:0] CMD_SECT = 2'h1;
  localparam logic [1:0] CMD_MASS = 2'h2;

  // flash array offset width (32 kbytes) and 1 kbyte sector index
  localparam int FA_W = 15;
  localparam int SECT_LSB = 10;

  typedef enum logic [0:0] {ST_LOAD, ST_RUN} boot_e;

endpackage

/* File: verilog/flash_prot_regs.sv */
// flash_prot_regs: configuration, protection and fault registers of a
// 32 kbyte program flash, with protection checking of commands.
// assumes command controller and nonvolatile field on the same clock.
//
// Contract
// - test register reads zero, ignores writes
// - config holds only two irq enables, key bit
// - key bit writable only when backdoor enabled
// - buffer-empty enable gates buffer-empty interrupt
// - complete enable gates all-done interrupt
// - key bit steers array writes to keys
// - array reads served while key bit set
// - normal mode protection may only grow
// - special mode protection written freely
// - protection loaded from nonvolatile byte at reset
// - protected program/erase rejected, violation flag set
// - mass erase refused if anything protected
// - high field protects (value+1) kbytes upward
// - low field decodes sizes, 111 none
// - low codes 000, 001, 010 protect everything
// - backdoor enabled only for code 10
// - violation flag blocks commands until cleared
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none

module flash_prot_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [flash_prot_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // nonvolatile configuration field
  input wire logic [7:0] nv_prot_byte,
  input wire logic [1:0] nv_backdoor_enable_field,
  // chip mode
  input wire logic special_mode,
  // command controller flags
  input wire logic buffer_empty_flag,
  input wire logic all_cmds_done_flag,
  // program or erase request from command controller
  input wire logic cmd_req,
  input wire logic [1:0] cmd_kind,
  input wire logic [flash_prot_pkg::FA_W-1:0] cmd_addr,
  output logic cmd_grant,
  output logic cmd_reject,
  // cpu access to the flash array
  input wire logic array_wr,
  input wire logic array_rd,
  output logic seq_start,
  output logic key_write,
  output logic array_rd_ok,
  // state shown to the rest of the flash
  output logic [7:0] protection_reg,
  output logic backdoor_key_write_en,
  output logic protection_violation_flag,
  output logic irq
);

  // ==========================================================
  // helpers

  // kbytes protected from the bottom of the array
  function automatic logic [5:0] low_kb(input logic [2:0] code);
    case (code)
      3'h3: low_kb = 6'h04;
      3'h4: low_kb = 6'h03;
      3'h5: low_kb = 6'h02;
      3'h6: low_kb = 6'h01;
      3'h7: low_kb = 6'h00;
      default: low_kb = flash_prot_pkg::KB_FULL;
    endcase
  endfunction

  // whether an array offset falls in a protected range
  function automatic logic is_prot(input logic [7:0] p,
                                   input logic [flash_prot_pkg::FA_W-1:0] a);
    logic [4:0] sect;
    logic [4:0] hi;
    sect = a[flash_prot_pkg::FA_W-1:flash_prot_pkg::SECT_LSB];
    hi = p[flash_prot_pkg::HI_MSB:flash_prot_pkg::HI_LSB];
    is_prot = ((hi != flash_prot_pkg::HI_NONE) && (sect > hi))
      || ({1'b0, sect} < low_kb(p[flash_prot_pkg::LO_MSB:0]));
  endfunction

  // ==========================================================
  // bus timing: one wait state, then the access takes effect
  // read data are captured on the edge ending the wait cycle, ready once waitrequest drops
  logic wait_r;
  logic req;
  logic take_rd;
  logic take_wr;
  logic [9:0] idx;
  logic wr_lane;

  assign req = read | write;
  assign take_rd = read & ~wait_r;
  assign take_wr = write & ~wait_r;
  assign idx = address[flash_prot_pkg::ADDR_W-1:flash_prot_pkg::IDX_LSB];
  assign wr_lane = take_wr & byteenable[0];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~(req & wait_r);
    end
  end

  // ==========================================================
  // reset load of nonvolatile values
  flash_prot_pkg::boot_e boot_r;
  logic [1:0] backdoor_enable_field_r;
  logic backdoor_enable_field_on;

  assign backdoor_enable_field_on = (backdoor_enable_field_r == flash_prot_pkg::BACKDOOR_ENABLE_FIELD_ON);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_r <= flash_prot_pkg::ST_LOAD;
    end else begin
      case (boot_r)
        flash_prot_pkg::ST_LOAD: boot_r <= flash_prot_pkg::ST_RUN;
        flash_prot_pkg::ST_RUN: boot_r <= flash_prot_pkg::ST_RUN;
        default: boot_r <= flash_prot_pkg::ST_LOAD;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      backdoor_enable_field_r <= 2'h0;
    end else if (boot_r == flash_prot_pkg::ST_LOAD) begin
      backdoor_enable_field_r <= nv_backdoor_enable_field;
    end
  end

  // ==========================================================
  // config register
  logic buf_ie_r;
  logic done_ie_r;
  logic key_en_r;
  logic cfg_wr;

  assign cfg_wr = wr_lane & (idx == flash_prot_pkg::IDX_CFG);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_ie_r <= flash_prot_pkg::CFG_RESET[flash_prot_pkg::CFG_BUF_IE];
      done_ie_r <= flash_prot_pkg::CFG_RESET[flash_prot_pkg::CFG_DONE_IE];
      key_en_r <= flash_prot_pkg::CFG_RESET[flash_prot_pkg::CFG_KEY_EN];
    end else if (cfg_wr) begin
      buf_ie_r <= writedata[flash_prot_pkg::CFG_BUF_IE];
      done_ie_r <= writedata[flash_prot_pkg::CFG_DONE_IE];
      if (backdoor_enable_field_on) begin
        key_en_r <= writedata[flash_prot_pkg::CFG_KEY_EN];
      end
    end
  end

  // ==========================================================
  // protection register
  logic [7:0] prot_r;
  logic prot_wr;
  logic grows;
  logic [4:0] new_hi;
  logic [4:0] old_hi;

  assign prot_wr = wr_lane & (idx == flash_prot_pkg::IDX_PROT);
  assign new_hi = writedata[flash_prot_pkg::HI_MSB:flash_prot_pkg::HI_LSB];
  assign old_hi = prot_r[flash_prot_pkg::HI_MSB:flash_prot_pkg::HI_LSB];
  // lower high start and larger low size both mean more protection
  assign grows = (new_hi <= old_hi)
    && (low_kb(writedata[flash_prot_pkg::LO_MSB:0])
        >= low_kb(prot_r[flash_prot_pkg::LO_MSB:0]));

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prot_r <= {flash_prot_pkg::HI_NONE, flash_prot_pkg::LO_NONE};
    end else if (boot_r == flash_prot_pkg::ST_LOAD) begin
      prot_r <= nv_prot_byte;
    end else if (prot_wr && (special_mode || grows)) begin
      prot_r <= writedata[7:0];
    end
  end

  // ==========================================================
  // command checking
  logic viol_r;
  logic any_prot;
  logic cmd_bad;
  logic cmd_go;
  logic mass_refuse;
  logic viol_set;
  logic viol_clr;

  assign any_prot = (old_hi != flash_prot_pkg::HI_NONE)
    || (prot_r[flash_prot_pkg::LO_MSB:0] != flash_prot_pkg::LO_NONE);
  assign mass_refuse = cmd_req && (cmd_kind == flash_prot_pkg::CMD_MASS)
    && any_prot;
  assign cmd_bad = mass_refuse
    || (cmd_req && (cmd_kind != flash_prot_pkg::CMD_MASS)
        && is_prot(prot_r, cmd_addr));
  assign viol_set = cmd_bad & ~viol_r;
  assign cmd_go = cmd_req & ~cmd_bad & ~viol_r
    & (boot_r == flash_prot_pkg::ST_RUN);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_grant <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      cmd_grant <= cmd_go;
      cmd_reject <= cmd_req & ~cmd_go;
    end
  end

  // software clears the flag by writing one to its fault bit
  assign viol_clr = wr_lane & (idx == flash_prot_pkg::IDX_FAULT)
    & writedata[flash_prot_pkg::FLT_VIOL];

  // violation flag: write one clears, a new violation wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      viol_r <= 1'b0;
    end else begin
      viol_r <= (viol_r & ~viol_clr) | cmd_bad;
    end
  end

  // ==========================================================
  // array access steering
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_start <= 1'b0;
      key_write <= 1'b0;
      array_rd_ok <= 1'b0;
    end else begin
      seq_start <= array_wr & ~key_en_r & ~viol_r;
      key_write <= array_wr & key_en_r;
      array_rd_ok <= array_rd;
    end
  end

  // ==========================================================
  // events and interrupt
  logic buf_d_r;
  logic done_d_r;
  logic [flash_prot_pkg::EV_N-1:0] evt_r;
  logic [flash_prot_pkg::EV_N-1:0] mask_r;
  logic [flash_prot_pkg::EV_N-1:0] evt_in;
  logic [flash_prot_pkg::EV_N-1:0] evt_clr;
  logic [7:0] rd_val;
  logic mask_wr;

  always_comb begin
    evt_in = '0;
    evt_in[flash_prot_pkg::EV_BUF] = buffer_empty_flag & ~buf_d_r;
    evt_in[flash_prot_pkg::EV_DONE] = all_cmds_done_flag & ~done_d_r;
    evt_in[flash_prot_pkg::EV_VIOL] = viol_set;
    evt_in[flash_prot_pkg::EV_MASS] = mass_refuse;
  end

  // a status read clears only the bits it returned
  assign evt_clr = (take_rd && idx == flash_prot_pkg::IDX_EVT)
    ? readdata[flash_prot_pkg::EV_N-1:0] : '0;
  assign mask_wr = wr_lane & (idx == flash_prot_pkg::IDX_MASK);

  // edge detectors idle low like their flags, so reset gives no false rise
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_d_r <= 1'b0;
      done_d_r <= 1'b0;
    end else begin
      buf_d_r <= buffer_empty_flag;
      done_d_r <= all_cmds_done_flag;
    end
  end

  // sticky status: a new event wins over a clearing read
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      evt_r <= '0;
    end else begin
      evt_r <= (evt_r & ~evt_clr) | evt_in;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_r <= '0;
    end else if (mask_wr) begin
      mask_r <= writedata[flash_prot_pkg::EV_N-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (buf_ie_r & buffer_empty_flag)
        | (done_ie_r & all_cmds_done_flag)
        | (|(evt_r & mask_r));
    end
  end

  // ==========================================================
  // read mux, sampled in the wait cycle
  always_comb begin
    rd_val = 8'h00;
    case (idx)
      flash_prot_pkg::IDX_TEST: rd_val = 8'h00;
      flash_prot_pkg::IDX_CFG: begin
        rd_val[flash_prot_pkg::CFG_BUF_IE] = buf_ie_r;
        rd_val[flash_prot_pkg::CFG_DONE_IE] = done_ie_r;
        rd_val[flash_prot_pkg::CFG_KEY_EN] = key_en_r;
      end
      flash_prot_pkg::IDX_PROT: rd_val = prot_r;
      flash_prot_pkg::IDX_EVT: rd_val[flash_prot_pkg::EV_N-1:0] = evt_r;
      flash_prot_pkg::IDX_MASK: rd_val[flash_prot_pkg::EV_N-1:0] = mask_r;
      flash_prot_pkg::IDX_FAULT: begin
        rd_val[flash_prot_pkg::FLT_VIOL] = viol_r;
        rd_val[flash_prot_pkg::FLT_SPECIAL] = special_mode;
        rd_val[flash_prot_pkg::FLT_BACKDOOR_ENABLE_FIELD] = backdoor_enable_field_on;
      end
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= '0;
    end else if (read & wait_r) begin
      readdata <= {24'h000000, rd_val};
    end
  end

  // ==========================================================
  // registered views
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      protection_reg <= {flash_prot_pkg::HI_NONE, flash_prot_pkg::LO_NONE};
    end else begin
      protection_reg <= prot_r;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      backdoor_key_write_en <= 1'b0;
    end else begin
      backdoor_key_write_en <= key_en_r;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      protection_violation_flag <= 1'b0;
    end else begin
      protection_violation_flag <= viol_r;
    end
  end

  assign waitrequest = wait_r;

endmodule // flash_prot_regs

`default_nettype wire

/* File: bench/flash_prot_chk.sv */
// flash_prot_chk: port assertions of the protection register block.
// assumes a bind onto flash_prot_regs, one clock domain.
`timescale 1ns/10ps
`default_nettype none

module flash_prot_chk (
  // clock, reset and bus
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [flash_prot_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // command and array side
  input wire logic [1:0] nv_backdoor_enable_field,
  input wire logic cmd_req,
  input wire logic [1:0] cmd_kind,
  input wire logic [flash_prot_pkg::FA_W-1:0] cmd_addr,
  input wire logic cmd_grant,
  input wire logic cmd_reject,
  input wire logic array_wr,
  input wire logic array_rd,
  input wire logic seq_start,
  input wire logic key_write,
  input wire logic array_rd_ok,
  input wire logic [7:0] protection_reg,
  input wire logic backdoor_key_write_en,
  input wire logic protection_violation_flag
);
  // ==========
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire rd_done = read && !waitrequest;
  wire [9:0] idx = address[11:2];
  wire [4:0] hi = protection_reg[7:3];

  a_test_zero: assert property (
    rd_done && idx == flash_prot_pkg::IDX_TEST |-> readdata == 32'h0)
    else $error("test register read not zero");
  a_cfg_bits: assert property (
    rd_done && idx == flash_prot_pkg::IDX_CFG |->
    (readdata & 32'hffffff1f) == 32'h0)
    else $error("config register unused bits not zero");
  a_key_gate: assert property (
    backdoor_key_write_en |-> nv_backdoor_enable_field == flash_prot_pkg::BACKDOOR_ENABLE_FIELD_ON)
    else $error("key bit set while backdoor disabled");
  a_key_steer: assert property (
    array_wr |=> (key_write == backdoor_key_write_en)
    && !(key_write && seq_start))
    else $error("array write not steered by key bit");
  a_rd_served: assert property (
    array_rd |=> array_rd_ok)
    else $error("array read not served");
  a_cmd_answer: assert property (
    cmd_req |=> cmd_grant != cmd_reject)
    else $error("command not answered once");
  a_mass_refuse: assert property (
    cmd_req && cmd_kind == flash_prot_pkg::CMD_MASS &&
    protection_reg != 8'hff |=> cmd_reject)
    else $error("mass erase allowed under protection");
  a_viol_blocks: assert property (
    cmd_req && protection_violation_flag |=> cmd_reject)
    else $error("command granted with violation pending");
  a_high_prot: assert property (
    cmd_req && cmd_kind != flash_prot_pkg::CMD_MASS && hi != 5'h1f &&
    cmd_addr[14:10] > hi |=> cmd_reject)
    else $error("high protected sector not refused");
endmodule // flash_prot_chk

bind flash_prot_regs flash_prot_chk chk_u (.ref_clk, .reset_n, .address,
  .read, .readdata, .waitrequest, .nv_backdoor_enable_field, .cmd_req, .cmd_kind,
  .cmd_addr, .cmd_grant, .cmd_reject, .array_wr, .array_rd, .seq_start,
  .key_write, .array_rd_ok, .protection_reg, .backdoor_key_write_en,
  .protection_violation_flag);

`default_nettype wire

/* File: bench/flash_cmd_model.sv */
// flash_cmd_model: command controller beside the protection block.
// assumes the same clock as the block; driven by tasks of the bench.
`timescale 1ns/10ps
`default_nettype none

module flash_cmd_model (
  // clock
  input wire logic ref_clk,
  // program or erase request
  output logic cmd_req,
  output logic [1:0] cmd_kind,
  output logic [flash_prot_pkg::FA_W-1:0] cmd_addr,
  input wire logic cmd_grant,
  input wire logic cmd_reject,
  // controller status levels
  output logic buffer_empty_flag,
  output logic all_cmds_done_flag
);
  // ==========
  // requests
  initial begin
    cmd_req = 1'b0;
    cmd_kind = 2'h3;
    cmd_addr = 15'h0;
    buffer_empty_flag = 1'b0;
    all_cmds_done_flag = 1'b0;
  end

  // answer is {grant, reject}
  task automatic issue(input logic [1:0] k, input logic [14:0] a,
                       output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    cmd_req <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    @(posedge ref_clk);
    cmd_req <= 1'b0;
    cmd_addr <= ~a;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cmd_grant !== 1'b1 && cmd_reject !== 1'b1 && n < 4);
    r = {cmd_grant, cmd_reject};
  endtask

  task automatic set_flags(input logic b, input logic d);
    @(posedge ref_clk);
    buffer_empty_flag <= b;
    all_cmds_done_flag <= d;
  endtask
endmodule // flash_cmd_model

`default_nettype wire

/* File: bench/tb_top.sv */
// tb_top: self-checking bench of the protection register block.
// assumes flash_prot_regs with bound checker and a command model.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // ==========
  // signals
  logic ref_clk, reset_n, read, write, waitrequest, special_mode, irq;
  logic [11:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata;
  logic [7:0] nv_prot_byte, protection_reg;
  logic [1:0] nv_backdoor_enable_field, cmd_kind;
  logic [14:0] cmd_addr;
  logic buffer_empty_flag, all_cmds_done_flag, cmd_req, cmd_grant;
  logic cmd_reject, array_wr, array_rd, seq_start, key_write, array_rd_ok;
  logic backdoor_key_write_en, protection_violation_flag;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  flash_prot_regs dut_u (.ref_clk, .reset_n, .address, .read, .write,
    .byteenable, .writedata, .readdata, .waitrequest, .nv_prot_byte,
    .nv_backdoor_enable_field, .special_mode, .buffer_empty_flag, .all_cmds_done_flag,
    .cmd_req, .cmd_kind, .cmd_addr, .cmd_grant, .cmd_reject, .array_wr,
    .array_rd, .seq_start, .key_write, .array_rd_ok, .protection_reg,
    .backdoor_key_write_en, .protection_violation_flag, .irq);
  flash_cmd_model cc_u (.ref_clk, .cmd_req, .cmd_kind, .cmd_addr,
    .cmd_grant, .cmd_reject, .buffer_empty_flag, .all_cmds_done_flag);

  // ==========
  // tasks
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [9:0] i,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    address <= {i, 2'b00};
    writedata <= {24'h0, d};
    write <= w;
    read <= !w;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask

  task automatic rd(input logic [9:0] i, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, i, 8'h00, q);
    chk($sformatf("register %h", i), e, q);
  endtask

  task automatic cmd(input logic [1:0] k, input logic [14:0] a,
                     input logic [1:0] e);
    logic [1:0] r;
    cc_u.issue(k, a, r);
    chk("command answer", {30'h0, e}, {30'h0, r});
  endtask

  // expected is {key_write, seq_start, array_rd_ok}
  task automatic arr(input logic w, input logic [2:0] e);
    @(posedge ref_clk);
    array_wr <= w;
    array_rd <= !w;
    @(posedge ref_clk);
    array_wr <= 1'b0;
    array_rd <= 1'b0;
    @(posedge ref_clk);
    chk("array pulses", {29'h0, e}, {29'h0, key_write, seq_start,
      array_rd_ok});
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(posedge ref_clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========
  // clock, timeout and tests
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report;
    end
  end

  initial begin : main
    logic [4:0] s;
    int kb[8];
    kb = '{32, 32, 32, 4, 3, 2, 1, 0};
    {reset_n, read, write, special_mode, array_wr, array_rd} = 6'h0;
    address = 12'h0;
    writedata = 32'h0;
    byteenable = 4'h1;
    nv_prot_byte = 8'hf6;
    nv_backdoor_enable_field = 2'h2;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(flash_prot_pkg::IDX_CFG, 32'h0);
    rd(flash_prot_pkg::IDX_PROT, 32'hf6);
    chk("protection view", 32'hf6, {24'h0, protection_reg});
    wr(flash_prot_pkg::IDX_TEST, 8'hff);
    rd(flash_prot_pkg::IDX_TEST, 32'h0);
    rd(10'h0ff, 32'h0);
    wr(flash_prot_pkg::IDX_CFG, 8'hff);
    rd(flash_prot_pkg::IDX_CFG, 32'he0);
    chk("key bit view", 32'h1, {31'h0, backdoor_key_write_en});
    arr(1'b1, 3'b100);
    arr(1'b0, 3'b001);
    wr(flash_prot_pkg::IDX_PROT, 8'hff);
    rd(flash_prot_pkg::IDX_PROT, 32'hf6);
    wr(flash_prot_pkg::IDX_PROT, 8'hed);
    rd(flash_prot_pkg::IDX_PROT, 32'hed);
    cmd(flash_prot_pkg::CMD_PROG, 15'h4000, 2'b10);
    cmd(flash_prot_pkg::CMD_SECT, 15'h7800, 2'b01);
    cmd(flash_prot_pkg::CMD_PROG, 15'h4000, 2'b01);
    rd(flash_prot_pkg::IDX_FAULT, 32'h5);
    chk("violation view", 32'h1, {31'h0, protection_violation_flag});
    rd(flash_prot_pkg::IDX_EVT, 32'h4);
    wr(flash_prot_pkg::IDX_FAULT, 8'h01);
    cmd(flash_prot_pkg::CMD_PROG, 15'h7400, 2'b10);
    cmd(flash_prot_pkg::CMD_PROG, 15'h0400, 2'b01);
    wr(flash_prot_pkg::IDX_FAULT, 8'h01);
    wr(flash_prot_pkg::IDX_MASK, 8'h08);
    cmd(flash_prot_pkg::CMD_MASS, 15'h0, 2'b01);
    irq_is(1'b1);
    rd(flash_prot_pkg::IDX_EVT, 32'hc);
    irq_is(1'b0);
    wr(flash_prot_pkg::IDX_FAULT, 8'h01);
    wr(flash_prot_pkg::IDX_CFG, 8'h40);
    arr(1'b1, 3'b010);
    cc_u.set_flags(1'b1, 1'b0);
    irq_is(1'b0);
    cc_u.set_flags(1'b1, 1'b1);
    irq_is(1'b1);
    wr(flash_prot_pkg::IDX_CFG, 8'h80);
    irq_is(1'b1);
    cc_u.set_flags(1'b0, 1'b1);
    irq_is(1'b0);
    special_mode <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(flash_prot_pkg::IDX_PROT, {5'h1f, 3'(c)});
      rd(flash_prot_pkg::IDX_PROT, {24'h0, 5'h1f, 3'(c)});
      s = 5'(kb[c]);
      if (kb[c] < 32)
        cmd(flash_prot_pkg::CMD_PROG, {s, 10'h0}, 2'b10);
      if (kb[c] > 0)
        cmd(flash_prot_pkg::CMD_PROG, {s - 5'h1, 10'h3ff}, 2'b01);
      wr(flash_prot_pkg::IDX_FAULT, 8'h01);
    end
    cmd(flash_prot_pkg::CMD_MASS, 15'h0, 2'b10);
    reset_n <= 1'b0;
    nv_backdoor_enable_field <= 2'h1;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    wr(flash_prot_pkg::IDX_CFG, 8'h20);
    rd(flash_prot_pkg::IDX_CFG, 32'h0);
    chk("key bit view", 32'h0, {31'h0, backdoor_key_write_en});
    final_report;
  end
endmodule // tb_top

`default_nettype wire
